/* File: rtl/dsb_decode.sv */
// instruction decoder for decrement, decrement-and-skip and absolute jump
// assumes the word is the instruction executing in the current cycle
`timescale 1ns/10ps
`default_nettype none

module dsb_decode (
  // instruction in
  input  wire logic [dsb_pkg::INSTR_W-1:0] instr_word,
  // decoded kind
  output logic                             is_decrement,
  output logic                             is_dec_skip,
  output logic                             is_jump,
  // decoded fields
  output dsb_pkg::dsb_dest_e               dest_sel,
  output logic [dsb_pkg::FADDR_W-1:0]      file_index,
  output logic [dsb_pkg::JUMP_W-1:0]       jump_target
);

  // ---------------------------------------------------------------
  // opcode matching
  // ---------------------------------------------------------------
  // six-bit opcode compare on the top of the word
  function automatic logic op6_match(input logic [dsb_pkg::INSTR_W-1:0] w,
                                     input logic [5:0] op);
    op6_match = (w[dsb_pkg::INSTR_W-1:dsb_pkg::OP6_LSB] == op);
  endfunction : op6_match

  // kind flags
  assign is_decrement = op6_match(instr_word, dsb_pkg::OP_DEC_REG);
  assign is_dec_skip  = op6_match(instr_word, dsb_pkg::OP_DEC_SKIP);
  assign is_jump      = (instr_word[dsb_pkg::INSTR_W-1:dsb_pkg::OP3_LSB]
                         == dsb_pkg::OP_JUMP);

  // ---------------------------------------------------------------
  // operand fields
  // ---------------------------------------------------------------
  // destination bit, file index and jump immediate
  assign dest_sel    = dsb_pkg::dsb_dest_e'(instr_word[dsb_pkg::DEST_BIT]);
  assign file_index  = instr_word[dsb_pkg::FADDR_LSB +: dsb_pkg::FADDR_W];
  assign jump_target = instr_word[dsb_pkg::JUMP_LSB +: dsb_pkg::JUMP_W];

endmodule : dsb_decode

`default_nettype wire

/* File: rtl/dsb_exec.sv */
// execution of decrement, decrement-and-skip-on-zero and absolute jump
// assumes one clock per instruction cycle, a register file read in the same
// cycle through file_index, and a fetch unit that supplies the word at pc
`timescale 1ns/10ps
`default_nettype none

module dsb_exec (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset,
  // fetched instruction
  input  wire logic [dsb_pkg::INSTR_W-1:0] instr_word,
  // page select, status bits 6 and 5
  input  wire logic [dsb_pkg::PAGE_W-1:0]  status_page,
  // register file read
  output logic [dsb_pkg::FADDR_W-1:0]      file_index,
  input  wire logic [dsb_pkg::DATA_W-1:0]  file_rdata,
  // register file write
  output logic                             file_we,
  output logic [dsb_pkg::FADDR_W-1:0]      file_waddr,
  output logic [dsb_pkg::DATA_W-1:0]       file_wdata,
  // core state
  output logic [dsb_pkg::DATA_W-1:0]       acc_value,
  output logic                             zero_flag,
  output logic [dsb_pkg::PC_W-1:0]         pc_value,
  output logic                             discard_next
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic                        is_decrement;
  logic                        is_dec_skip;
  logic                        is_jump;
  dsb_pkg::dsb_dest_e          dest_sel;
  logic [dsb_pkg::JUMP_W-1:0]  jump_target;

  dsb_decode u_decode (
    .instr_word   (instr_word),
    .is_decrement (is_decrement),
    .is_dec_skip  (is_dec_skip),
    .is_jump      (is_jump),
    .dest_sel     (dest_sel),
    .file_index   (file_index),
    .jump_target  (jump_target)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [dsb_pkg::PC_W-1:0]    pc_reg;
  logic [dsb_pkg::DATA_W-1:0]  acc_reg;
  logic                        zero_reg;
  logic                        discard_reg;
  logic                        we_reg;
  logic [dsb_pkg::FADDR_W-1:0] waddr_reg;
  logic [dsb_pkg::DATA_W-1:0]  wdata_reg;

  // ---------------------------------------------------------------
  // execute qualifiers
  // ---------------------------------------------------------------
  logic                        live;
  logic                        do_dec;
  logic                        do_dsz;
  logic                        do_jump;
  logic [dsb_pkg::DATA_W-1:0]  dec_result;
  logic                        result_zero;
  logic                        do_skip;
  logic [dsb_pkg::PC_W-1:0]    pc_next;

  // a discarded word runs as a no-op
  assign live        = !discard_reg;
  assign do_dec      = live && is_decrement;
  assign do_dsz      = live && is_dec_skip;
  assign do_jump     = live && is_jump;
  assign dec_result  = file_rdata - dsb_pkg::DATA_ONE;
  assign result_zero = (dec_result == '0);
  assign do_skip     = do_dsz && result_zero;

  // next fetch address
  always_comb begin
    pc_next = pc_reg + dsb_pkg::PC_STEP;
    if (do_jump) begin
      pc_next = {status_page, jump_target};
    end
  end

  // program counter
  always_ff @(posedge clock) begin
    if (reset) begin
      pc_reg <= dsb_pkg::PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // discard of the fetched word after a skip or a jump
  always_ff @(posedge clock) begin
    if (reset) begin
      discard_reg <= 1'b0;
    end else begin
      discard_reg <= do_skip || do_jump;
    end
  end

  // accumulator destination
  always_ff @(posedge clock) begin
    if (reset) begin
      acc_reg <= dsb_pkg::ACC_RESET;
    end else if ((do_dec || do_dsz) && dest_sel == dsb_pkg::DSB_DEST_ACC) begin
      acc_reg <= dec_result;
    end
  end

  // zero flag, only the plain decrement touches it
  always_ff @(posedge clock) begin
    if (reset) begin
      zero_reg <= dsb_pkg::ZERO_RESET;
    end else if (do_dec) begin
      zero_reg <= result_zero;
    end
  end

  // register file write-back
  always_ff @(posedge clock) begin
    if (reset) begin
      we_reg    <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      we_reg    <= (do_dec || do_dsz) && dest_sel == dsb_pkg::DSB_DEST_FILE;
      waddr_reg <= file_index;
      wdata_reg <= dec_result;
    end
  end

  // outputs
  assign file_we      = we_reg;
  assign file_waddr   = waddr_reg;
  assign file_wdata   = wdata_reg;
  assign acc_value    = acc_reg;
  assign zero_flag    = zero_reg;
  assign pc_value     = pc_reg;
  assign discard_next = discard_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence dsz_zero_s;
    do_dsz && result_zero;
  endsequence

  sequence dsz_nonzero_s;
    do_dsz && !result_zero;
  endsequence

  sequence jump_s;
    do_jump;
  endsequence

  sequence dropped_s;
    discard_next;
  endsequence

  dec_zero_a: assert property (@(posedge clock) disable iff (reset)
    do_dec |=> zero_flag == ($past(file_rdata) == dsb_pkg::DATA_ONE))
    else $error("decrement zero flag wrong");

  dec_to_acc_a: assert property (@(posedge clock) disable iff (reset)
    (do_dec && dest_sel == dsb_pkg::DSB_DEST_ACC)
      |=> acc_value == $past(file_rdata) - dsb_pkg::DATA_ONE && !file_we)
    else $error("decrement to accumulator wrong");

  dec_to_file_a: assert property (@(posedge clock) disable iff (reset)
    (do_dec && dest_sel == dsb_pkg::DSB_DEST_FILE) |=> file_we
      && file_wdata == $past(file_rdata) - dsb_pkg::DATA_ONE
      && file_waddr == $past(file_index) && $stable(acc_value))
    else $error("decrement to file wrong");

  dsz_flags_a: assert property (@(posedge clock) disable iff (reset)
    do_dsz |=> $stable(zero_flag))
    else $error("skip decrement touched zero flag");

  dsz_to_file_a: assert property (@(posedge clock) disable iff (reset)
    (do_dsz && dest_sel == dsb_pkg::DSB_DEST_FILE) |=> file_we
      && file_wdata == $past(file_rdata) - dsb_pkg::DATA_ONE
      && file_waddr == $past(file_index) && $stable(acc_value))
    else $error("skip decrement to file wrong");

  dsz_to_acc_a: assert property (@(posedge clock) disable iff (reset)
    (do_dsz && dest_sel == dsb_pkg::DSB_DEST_ACC)
      |=> acc_value == $past(file_rdata) - dsb_pkg::DATA_ONE && !file_we)
    else $error("skip decrement to accumulator wrong");

  dsz_skip_a: assert property (@(posedge clock) disable iff (reset)
    dsz_zero_s |=> discard_next ##1 (!discard_next && !file_we))
    else $error("zero skip did not discard one word");

  drop_quiet_a: assert property (@(posedge clock) disable iff (reset)
    dropped_s |=> !file_we && !discard_next && $stable(acc_value) && $stable(zero_flag)
      && pc_value == $past(pc_value) + dsb_pkg::PC_STEP)
    else $error("discarded word had an effect");

  jump_flags_a: assert property (@(posedge clock) disable iff (reset)
    jump_s |=> $stable(zero_flag) && $stable(acc_value) && !file_we)
    else $error("jump changed state");

  jump_low_a: assert property (@(posedge clock) disable iff (reset)
    jump_s |=> pc_value[dsb_pkg::JUMP_W-1:0] == $past(jump_target))
    else $error("jump low bits wrong");

  jump_page_a: assert property (@(posedge clock) disable iff (reset)
    jump_s |=> pc_value[dsb_pkg::PC_W-1:dsb_pkg::JUMP_W] == $past(status_page))
    else $error("jump page bits wrong");

  jump_two_a: assert property (@(posedge clock) disable iff (reset)
    jump_s |=> discard_next && !do_jump && !do_dec && !do_dsz)
    else $error("jump not two cycles");

  dsz_noskip_a: assert property (@(posedge clock) disable iff (reset)
    dsz_nonzero_s |=> !discard_next && pc_value == $past(pc_value) + dsb_pkg::PC_STEP)
    else $error("nonzero skip decrement misbehaved");

endmodule : dsb_exec

`default_nettype wire

/* File: rtl/dsb_pkg.sv */
// package of constants for the decrement, skip and jump execution block
// assumes a 12-bit instruction word and an 11-bit program counter
package dsb_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int INSTR_W = 12;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 11;
  localparam int FADDR_W = 5;
  localparam int JUMP_W  = 9;
  localparam int PAGE_W  = 2;

  // ---------------------------------------------------------------
  // opcode patterns and field positions
  // ---------------------------------------------------------------
  localparam logic [5:0] OP_DEC_REG  = 6'h03;  // 0000 11df ffff
  localparam logic [5:0] OP_DEC_SKIP = 6'h0b;  // 0010 11df ffff
  localparam logic [2:0] OP_JUMP     = 3'h5;   // 101k kkkk kkkk
  localparam int OP6_LSB    = 6;
  localparam int OP3_LSB    = 9;
  localparam int DEST_BIT   = 5;
  localparam int FADDR_LSB  = 0;
  localparam int JUMP_LSB   = 0;

  // ---------------------------------------------------------------
  // reset values, pc step and the decrement operand
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0]   PC_RESET   = 11'h000;
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic              ZERO_RESET = 1'b0;
  localparam logic [PC_W-1:0]   PC_STEP    = 11'h001;
  localparam logic [DATA_W-1:0] DATA_ONE   = 8'h01;

  // destination choice of the decrements
  typedef enum logic {
    DSB_DEST_ACC,
    DSB_DEST_FILE
  } dsb_dest_e;

endpackage : dsb_pkg

/* File: tb/testbench.sv */
// self-checking bench for the decrement, skip and jump execution block
// assumes dsb_pkg and dsb_exec are compiled first; the bench plays fetch and file
`timescale 1ns/10ps
`default_nettype none

module testbench;

  // ---------------------------------------------------------------
  // stimulus rows: inputs beside the outputs they should give
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] instr;
    logic [1:0]  page;
    logic [7:0]  rdata;
    logic        we;
    logic [7:0]  wdata;
    logic [7:0]  acc;
    logic        zero;
    logic [10:0] pc;
    logic        disc;
  } dsb_row_s;

  localparam int NROWS = 11;
  localparam dsb_row_s ROWS [NROWS] = '{
    '{12'h0c5, 2'h0, 8'h01, 1'b0, 8'h00, 8'h00, 1'b1, 11'h001, 1'b0},
    '{12'h0e5, 2'h0, 8'h00, 1'b1, 8'hff, 8'h00, 1'b0, 11'h002, 1'b0},
    '{12'h0df, 2'h0, 8'h80, 1'b0, 8'h00, 8'h7f, 1'b0, 11'h003, 1'b0},
    '{12'h2e3, 2'h0, 8'h02, 1'b1, 8'h01, 8'h7f, 1'b0, 11'h004, 1'b0},
    '{12'h2c4, 2'h0, 8'h01, 1'b0, 8'h00, 8'h00, 1'b0, 11'h005, 1'b1},
    '{12'h0c0, 2'h0, 8'h01, 1'b0, 8'h00, 8'h00, 1'b1, 11'h007, 1'b0},
    '{12'h2e1, 2'h0, 8'h05, 1'b1, 8'h04, 8'h00, 1'b1, 11'h008, 1'b0},
    '{12'ha23, 2'h2, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 11'h423, 1'b1},
    '{12'hbff, 2'h3, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 11'h7ff, 1'b1},
    '{12'ha00, 2'h0, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 11'h000, 1'b1},
    '{12'h000, 2'h1, 8'h33, 1'b0, 8'h00, 8'h00, 1'b1, 11'h002, 1'b0}
  };

  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  logic        clock;
  logic        reset;
  logic [11:0] instr_word;
  logic [1:0]  status_page;
  logic [7:0]  file_rdata;
  logic [4:0]  file_index;
  logic        file_we;
  logic [4:0]  file_waddr;
  logic [7:0]  file_wdata;
  logic [7:0]  acc_value;
  logic        zero_flag;
  logic [10:0] pc_value;
  logic        discard_next;
  int          mismatches;
  int          total_checks;

  dsb_exec uut (
    .clock(clock), .reset(reset), .instr_word(instr_word), .status_page(status_page),
    .file_index(file_index), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .acc_value(acc_value),
    .zero_flag(zero_flag), .pc_value(pc_value), .discard_next(discard_next)
  );

  // clock of 50 ns period
  always #25 clock = ~clock;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] seen);
    total_checks++;
    if (exp !== seen) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // one instruction cycle: drive at falling edge, execute, look one cycle later
  task automatic step(input logic [11:0] w, input logic [1:0] pg, input logic [7:0] rd);
    instr_word  = w;
    status_page = pg;
    file_rdata  = rd;
    #1 chk("file_index", w[4:0], file_index);
    @(negedge clock);
  endtask : step

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [10:0] pc_hold;
    logic [7:0]  acc_hold;
    logic        zero_hold;
    clock = 1'b0; reset = 1'b1; mismatches = 0; total_checks = 0;
    instr_word = 12'h000; status_page = 2'h0; file_rdata = 8'h00;
    repeat (6) @(negedge clock);
    reset = 1'b0;
    // table of ordinary cases, skip and jump discards included
    for (int i = 0; i < NROWS; i++) begin
      step(ROWS[i].instr, ROWS[i].page, ROWS[i].rdata);
      chk("file_we", ROWS[i].we, file_we);
      if (ROWS[i].we) chk("file_waddr", ROWS[i].instr[4:0], file_waddr);
      if (ROWS[i].we) chk("file_wdata", ROWS[i].wdata, file_wdata);
      chk("acc_value", ROWS[i].acc, acc_value);
      chk("zero_flag", ROWS[i].zero, zero_flag);
      chk("pc_value", ROWS[i].pc, pc_value);
      chk("discard_next", ROWS[i].disc, discard_next);
      if (ROWS[i].disc) begin
        // word already fetched must be dropped: no write, no jump, pc one on
        pc_hold = ROWS[i].pc + 11'h001;
        step(i % 2 ? 12'ha7f : 12'h0e0, 2'h3, 8'h10);
        chk("drop_we", 1'b0, file_we);
        chk("drop_acc", ROWS[i].acc, acc_value);
        chk("drop_pc", pc_hold, pc_value);
        chk("drop_disc", 1'b0, discard_next);
      end
    end
    // reset in mid-run right after a jump, with a word offered during it
    step(12'ha55, 2'h3, 8'h00);
    chk("jump_pc", 11'h655, pc_value);
    reset = 1'b1;
    step(12'h0c5, 2'h0, 8'h05);
    chk("rst_pc", 11'h000, pc_value);
    chk("rst_acc", 8'h00, acc_value);
    chk("rst_zero", 1'b0, zero_flag);
    chk("rst_disc", 1'b0, discard_next);
    chk("rst_we", 1'b0, file_we);
    chk("rst_waddr", 5'h00, file_waddr);
    chk("rst_wdata", 8'h00, file_wdata);
    reset = 1'b0;
    // flags held across a zero skip straight after reset
    acc_hold = 8'h00;
    zero_hold = 1'b0;
    step(12'h2c9, 2'h0, 8'h01);
    chk("skip_zero", zero_hold, zero_flag);
    chk("skip_acc", acc_hold, acc_value);
    chk("skip_disc", 1'b1, discard_next);
    finish_test();
  end

  // cut a hang short
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end

endmodule : testbench

`default_nettype wire
